// >>> hdl/sir_endec_map.vh
/*
 * Constants for the serial-infrared pulse encoder/decoder: APB register
 * offsets, field positions, reset values and timing counts.
 * Assumes it is included by bare name from the design file.
 */
// Behaviour
// - the baud tick divides the crystal by 2,4,12,24,6,48,96 per rate code.
// - encoder and decoder advance on a tick at sixteen times the baud rate.
// - each space bit from the uart gives exactly one optical pulse.
// - a mark bit keeps the optical output low with no pulse.
// - after a falling uart edge wait 7 ticks, drive high 3 ticks, then low.
// - consecutive spaces give pulses one bit time apart, each centred.
// - every falling edge on the optical receive input is one pulse.
// - each received pulse drives the uart receive output low 16 ticks.
// - the stretched space lasts at least three quarters of a bit time.
// - in monoshot mode each modulator rising edge gives 6 crystal cycles.
// - while asleep the block neither transmits nor receives.
`ifndef SIR_ENDEC_MAP_VH
`define SIR_ENDEC_MAP_VH

// register byte offsets
`define CTRL_OFS 12'h000
`define STATUS_OFS 12'h004
`define COUNT_OFS 12'h008

// control fields
`define CTRL_RATE_LSB 0
`define CTRL_RATE_MSB 2
`define CTRL_SHAPE_BIT 3
`define CTRL_EXTCLK_BIT 4
`define CTRL_SLEEP_BIT 5
`define CTRL_RESET 6'h00

// status fields
`define ST_ENC_BUSY_BIT 0
`define ST_DEC_BUSY_BIT 1
`define ST_SLEEP_BIT 2
`define ST_MONO_BUSY_BIT 3

// divide ratios per rate code
`define DIV_115200 7'h02
`define DIV_57600 7'h04
`define DIV_19200 7'h0c
`define DIV_9600 7'h18
`define DIV_38400 7'h06
`define DIV_4800 7'h30
`define DIV_2400 7'h60

// encoder and decoder timing in sixteenth-bit ticks
`define ENC_WAIT_TICKS 4'h7
`define ENC_HIGH_TICKS 4'h3
`define ENC_CONFIRM_TICK 4'h1
`define BIT_TICKS_LAST 4'hf

// monoshot length in crystal cycles
`define MONO_CYCLES 3'h6

`endif

// >>> hdl/sir_pulse_endec.v
/*
 * Serial-infrared pulse encoder and decoder with an APB control port.
 * pclk stands in for the crystal; the sixteen-times bit clock comes either
 * from the internal divider or from the external clock pin. Assumes the
 * uart transmit line, the optical receive line, the external bit clock and
 * the sleep pin are asynchronous to pclk.
 */
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "sir_endec_map.vh"

module sir_pulse_endec #(
	parameter CNT_W = 8
) (
	input wire pclk, // crystal-rate clock
	input wire presetn, // asynchronous reset, active low
	input wire psel, // apb select
	input wire penable, // apb access phase
	input wire pwrite, // apb write
	input wire [11:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output wire [31:0] prdata, // apb read data
	output wire pready, // apb ready, always high
	output wire pslverr, // unmapped address
	input wire uart_tx_in, // uart transmit line
	output reg uart_rx_out, // uart receive line
	input wire optical_rx_in, // transceiver receive line
	output reg optical_tx_out, // transceiver transmit line
	input wire sixteen_x_bit_clock, // external 16x bit clock
	input wire sleep_in // power-down pin, active high
);

	// synchronisers: first stage read only by second
	reg [3:0] sync1_r;
	reg [3:0] sync2_r;
	reg tx_d_r;
	reg rx_d_r;
	reg xclk_d_r;

	// control and counters
	reg [5:0] ctrl_r;
	reg [CNT_W-1:0] tx_cnt_r;
	reg [CNT_W-1:0] rx_cnt_r;

	// divider
	reg [6:0] div_cnt_r;
	reg [6:0] div_ratio;

	// encoder
	reg enc_busy_r;
	reg [3:0] enc_tick_r;
	reg mod_r;
	reg mod_d_r;

	// monoshot
	reg [2:0] mono_cnt_r;

	// decoder
	reg dec_busy_r;
	reg [3:0] dec_tick_r;

	wire tx_s;
	wire rx_s;
	wire xclk_s;
	wire sleep_s;
	wire asleep;
	wire tick;
	wire tx_fall;
	wire rx_fall;
	wire mod_rise;
	wire mono_mode;
	wire [2:0] rate;
	wire wr_en;
	wire rd_sel_ok;
	reg [31:0] rd_data;

	assign tx_s = sync2_r[0];
	assign rx_s = sync2_r[1];
	assign xclk_s = sync2_r[2];
	assign sleep_s = sync2_r[3];
	assign rate = ctrl_r[`CTRL_RATE_MSB:`CTRL_RATE_LSB];
	assign mono_mode = ctrl_r[`CTRL_SHAPE_BIT];

	// pin or register may put the block to sleep
	assign asleep = sleep_s | ctrl_r[`CTRL_SLEEP_BIT];

	// two-stage synchronisers for the four asynchronous inputs; apb inputs are used directly
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// idle levels except sleep, which resets high; else the edge detectors see a false edge
			sync1_r <= 4'hb;
			sync2_r <= 4'hb;
		end else begin
			sync1_r <= {sleep_in, sixteen_x_bit_clock, optical_rx_in,
				uart_tx_in};
			sync2_r <= sync1_r;
		end
	end

	// edge detect stages, all on synchronised levels
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_d_r <= 1'b1;
			rx_d_r <= 1'b1;
			xclk_d_r <= 1'b0;
		end else begin
			tx_d_r <= tx_s;
			rx_d_r <= rx_s;
			xclk_d_r <= xclk_s;
		end
	end

	assign tx_fall = tx_d_r & ~tx_s;
	assign rx_fall = rx_d_r & ~rx_s;

	// divide ratio per rate code; unused code 111 falls back to 2
	always @* begin
		case (rate)
		3'h0: div_ratio = `DIV_115200;
		3'h1: div_ratio = `DIV_57600;
		3'h2: div_ratio = `DIV_19200;
		3'h3: div_ratio = `DIV_9600;
		3'h4: div_ratio = `DIV_38400;
		3'h5: div_ratio = `DIV_4800;
		3'h6: div_ratio = `DIV_2400;
		default: div_ratio = `DIV_115200;
		endcase
	end

	// free-running divider; wraps early if the ratio shrinks mid-count
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_r <= 7'h00;
		end else if (asleep || div_cnt_r >= div_ratio - 7'h01) begin
			div_cnt_r <= 7'h00;
		end else begin
			div_cnt_r <= div_cnt_r + 7'h01;
		end
	end

	// one tick per sixteenth of a bit, internal or external source
	assign tick = asleep ? 1'b0 :
		ctrl_r[`CTRL_EXTCLK_BIT] ? (xclk_s & ~xclk_d_r) :
		(div_cnt_r == div_ratio - 7'h01);

	// encoder: a falling uart edge opens a bit window of 16 ticks
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enc_busy_r <= 1'b0;
			enc_tick_r <= 4'h0;
		end else if (asleep) begin
			enc_busy_r <= 1'b0;
			enc_tick_r <= 4'h0;
		end else if (!enc_busy_r) begin
			if (tx_fall) begin
				enc_busy_r <= 1'b1;
				enc_tick_r <= 4'h0;
			end
		end else if (tick) begin
			if (enc_tick_r == `BIT_TICKS_LAST) begin
				// another space follows: next centred pulse one bit on
				enc_busy_r <= ~tx_s;
				enc_tick_r <= 4'h0;
			end else if (enc_tick_r == `ENC_CONFIRM_TICK && tx_s) begin
				// a partial first tick ends the window before the bit
				// does; by now the line shows the next bit, a mark stops
				enc_busy_r <= 1'b0;
				enc_tick_r <= 4'h0;
			end else begin
				enc_tick_r <= enc_tick_r + 4'h1;
			end
		end
	end

	// modulator output: high during ticks 7..9 of each space window
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mod_r <= 1'b0;
		end else begin
			mod_r <= enc_busy_r && !asleep &&
				enc_tick_r >= `ENC_WAIT_TICKS &&
				enc_tick_r < `ENC_WAIT_TICKS + `ENC_HIGH_TICKS;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mod_d_r <= 1'b0;
		end else begin
			mod_d_r <= mod_r;
		end
	end

	assign mod_rise = mod_r & ~mod_d_r;

	// monoshot: fixed crystal-cycle pulse, independent of rate code
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mono_cnt_r <= 3'h0;
		end else if (asleep) begin
			mono_cnt_r <= 3'h0;
		end else if (mod_rise) begin
			mono_cnt_r <= `MONO_CYCLES;
		end else if (mono_cnt_r != 3'h0) begin
			mono_cnt_r <= mono_cnt_r - 3'h1;
		end
	end

	// optical output: registered, chosen by pulse shape select
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			optical_tx_out <= 1'b0;
		end else if (asleep) begin
			optical_tx_out <= 1'b0;
		end else if (mono_mode) begin
			optical_tx_out <= mod_rise | (mono_cnt_r > 3'h1);
		end else begin
			optical_tx_out <= mod_r;
		end
	end

	// decoder: each falling edge restarts a 16-tick space
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dec_busy_r <= 1'b0;
			dec_tick_r <= 4'h0;
		end else if (asleep) begin
			dec_busy_r <= 1'b0;
			dec_tick_r <= 4'h0;
		end else if (rx_fall) begin
			dec_busy_r <= 1'b1;
			dec_tick_r <= 4'h0;
		end else if (dec_busy_r && tick) begin
			// a full 16 ticks keeps the space well past 3/4 bit
			if (dec_tick_r == `BIT_TICKS_LAST) begin
				dec_busy_r <= 1'b0;
			end else begin
				dec_tick_r <= dec_tick_r + 4'h1;
			end
		end
	end

	// uart receive line idles high, low while stretching
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uart_rx_out <= 1'b1;
		end else begin
			uart_rx_out <= ~((dec_busy_r | rx_fall) & ~asleep);
		end
	end

	// apb: zero wait states, writes land at the access edge
	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite;
	assign rd_sel_ok = (paddr == `CTRL_OFS) || (paddr == `STATUS_OFS) ||
		(paddr == `COUNT_OFS);
	assign pslverr = psel & penable & ~rd_sel_ok;

	// control register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `CTRL_RESET;
		end else if (wr_en && paddr == `CTRL_OFS) begin
			ctrl_r <= pwdata[5:0];
		end
	end

	// pulse counters; a write to count clears both, a pulse wins the clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_cnt_r <= {CNT_W{1'b0}};
			rx_cnt_r <= {CNT_W{1'b0}};
		end else begin
			if (mod_rise) begin
				tx_cnt_r <= tx_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
			end else if (wr_en && paddr == `COUNT_OFS) begin
				tx_cnt_r <= {CNT_W{1'b0}};
			end
			if (rx_fall && !asleep) begin
				rx_cnt_r <= rx_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
			end else if (wr_en && paddr == `COUNT_OFS) begin
				rx_cnt_r <= {CNT_W{1'b0}};
			end
		end
	end

	// read mux; unmapped reads return zero
	always @* begin
		rd_data = 32'h00000000;
		case (paddr)
		`CTRL_OFS: rd_data[5:0] = ctrl_r;
		`STATUS_OFS: begin
			rd_data[`ST_ENC_BUSY_BIT] = enc_busy_r;
			rd_data[`ST_DEC_BUSY_BIT] = dec_busy_r;
			rd_data[`ST_SLEEP_BIT] = asleep;
			rd_data[`ST_MONO_BUSY_BIT] = (mono_cnt_r != 3'h0);
		end
		`COUNT_OFS: begin
			rd_data[CNT_W-1:0] = tx_cnt_r;
			rd_data[16+CNT_W-1:16] = rx_cnt_r;
		end
		default: rd_data = 32'h00000000;
		endcase
	end

	assign prdata = (psel & ~pwrite) ? rd_data : 32'h00000000;

endmodule

// >>> bench/sir_endec_chk.sv
/* Checker for the infrared pulse codec: run-length counters, assertions.
 * Assumes it is bound to the codec top and sees only its ports. */
`timescale 1ns/1ps
module sir_endec_chk (
	input wire pclk, // crystal clock
	input wire presetn, // reset, active low
	input wire psel, // apb select
	input wire penable, // apb access
	input wire pwrite, // apb write
	input wire [11:0] paddr, // apb address
	input wire [31:0] pwdata, // apb data
	input wire uart_tx_in, // uart transmit
	input wire uart_rx_out, // uart receive
	input wire optical_rx_in, // optical receive
	input wire optical_tx_out, // optical transmit
	input wire sleep_in // power-down pin
);
	localparam int DVT [8] = '{2, 4, 12, 24, 6, 48, 96, 2};
	localparam int XDIV = 4; // bench runs the 16x pin at a quarter of pclk
	logic [5:0] ctl_r;
	int hc, lc, gc, sc, dv;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign dv = ctl_r[4] ? XDIV : DVT[ctl_r[2:0]];
	// control shadow; gap and space counters saturate so long idle never wraps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_r <= 6'h00;
			hc <= 0;
			lc <= 0;
			gc <= 4000;
			sc <= 4000;
		end else begin
			if (psel && penable && pwrite && paddr == 12'h000)
				ctl_r <= pwdata[5:0];
			hc <= optical_tx_out ? hc + 1 : 0;
			lc <= uart_rx_out ? 0 : lc + 1;
			// a rate change breaks the spacing, so restart from far away
			if (psel && penable && pwrite && paddr == 12'h000)
				gc <= 4000;
			else
				gc <= $rose(optical_tx_out) ? 1 : (gc < 4000 ? gc + 1 : gc);
			sc <= !uart_tx_in ? 0 : (sc < 4000 ? sc + 1 : sc);
		end
	end
	chk_pulse_width: assert property (
		$fell(optical_tx_out) && !ctl_r[3] |-> hc == 3 * dv)
		else $error("optical pulse width wrong");
	chk_mono_width: assert property (
		$fell(optical_tx_out) && ctl_r[3] |-> hc == 6)
		else $error("monoshot width wrong");
	chk_pulse_gap: assert property (
		$rose(optical_tx_out) && gc < 20 * dv |-> gc == 16 * dv)
		else $error("pulse spacing wrong");
	chk_space_cause: assert property (
		$rose(optical_tx_out) |-> sc < 8)
		else $error("pulse without a space");
	chk_rx_follow: assert property (
		$fell(optical_rx_in) && !sleep_in && !ctl_r[5]
		|-> ##[1:6] !uart_rx_out)
		else $error("received pulse not seen");
	chk_stretch_len: assert property (
		$rose(uart_rx_out) |-> lc >= 15 * dv && lc <= 16 * dv + 2)
		else $error("stretch length wrong");
	chk_stretch_min: assert property (
		$rose(uart_rx_out) |-> lc >= 12 * dv)
		else $error("stretch too short");
	chk_sleep_idle: assert property (
		(sleep_in || ctl_r[5])[*4] |-> !optical_tx_out && uart_rx_out)
		else $error("activity while asleep");
	chk_reset_idle: assert property (
		$rose(presetn) |-> !optical_tx_out && uart_rx_out)
		else $error("outputs not idle after reset");
	cover property ($fell(optical_tx_out) && ctl_r[3]);
	cover property ($fell(optical_tx_out) && !ctl_r[3]);
	cover property ($rose(uart_rx_out));
endmodule
bind sir_pulse_endec sir_endec_chk u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .uart_tx_in(uart_tx_in), .uart_rx_out(uart_rx_out),
	.optical_rx_in(optical_rx_in), .optical_tx_out(optical_tx_out),
	.sleep_in(sleep_in));

// >>> bench/ir_far_model.sv
/* Far side model: uart transmitter and optical receiver front end.
 * Assumes its tasks are called from a process just after pclk edges. */
`timescale 1ns/1ps
module ir_far_model (
	input wire pclk, // crystal clock
	output logic uart_tx_in = 1'b1, // idles high, led off
	output logic optical_rx_in = 1'b1 // received pulses, active low
);
	// start, eight data bits lsb first, stop; 16*d cycles per bit
	task send_byte(input logic [7:0] b, input int d);
		logic [9:0] f;
		begin
			f = {1'b1, b, 1'b0};
			for (int i = 0; i < 10; i++) begin
				uart_tx_in <= f[i];
				repeat (16 * d) @(posedge pclk);
			end
		end
	endtask
	// short low pulse as a transceiver delivers it
	task ir_pulse;
		begin
			optical_rx_in <= 1'b0;
			repeat (3) @(posedge pclk);
			optical_rx_in <= 1'b1;
		end
	endtask
endmodule

// >>> bench/test_sir_pulse_endec.sv
/* Bench for the infrared pulse codec: apb setup, frames via the model.
 * Assumes the codec map header is on the include path. */
`timescale 1ns/1ps
`include "sir_endec_map.vh"
module test_sir_pulse_endec;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, sleep_in = 1'b0, e, xclk = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, r;
	wire [31:0] prdata;
	wire pready, pslverr, uart_tx_in, uart_rx_out, optical_rx_in;
	wire optical_tx_out;
	int n_mismatch = 0, compares = 0, npulse = 0;
	int dv [9] = '{2, 4, 12, 24, 6, 48, 96, 2, 4};
	sir_pulse_endec u_sir_pulse_endec (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .uart_tx_in(uart_tx_in),
		.uart_rx_out(uart_rx_out), .optical_rx_in(optical_rx_in),
		.optical_tx_out(optical_tx_out), .sixteen_x_bit_clock(xclk),
		.sleep_in(sleep_in));
	ir_far_model u_ir_far_model (.pclk(pclk), .uart_tx_in(uart_tx_in),
		.optical_rx_in(optical_rx_in));
	initial begin
		forever #5 pclk = ~pclk;
	end
	// external 16x clock at a quarter of pclk, free running
	initial begin
		forever begin
			repeat (2) @(posedge pclk);
			xclk <= ~xclk;
		end
	end
	// each rising optical edge is one emitted pulse
	always @(posedge optical_tx_out) npulse++;
	task final_report;
		begin
			$display("compares %0d mismatches %0d", compares, n_mismatch);
			if (n_mismatch == 0 && compares > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	task chk(input string nm, input logic [31:0] got, exp);
		begin
			compares++;
			if (got !== exp) begin
				n_mismatch++;
				$display("BAD %s exp %h got %h", nm, exp, got);
			end
		end
	endtask
	// a wait that ran out ends the run
	task tmo(input bit hit);
		begin
			if (hit) begin
				n_mismatch++;
				final_report;
			end
		end
	endtask
	// idle edge first, so back-to-back calls never clash on psel
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			k = 0;
			do begin
				@(posedge pclk);
				k++;
			end while (pready !== 1'b1 && k < 16);
			tmo(pready !== 1'b1);
			r = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task t_regs;
		begin
			chk("tx_idle", optical_tx_out, 0);
			chk("rx_idle", uart_rx_out, 1);
			apb(1'b0, `CTRL_OFS, 0);
			chk("ctrl_rst", r, `CTRL_RESET);
			apb(1'b1, `CTRL_OFS, 32'h0000000a);
			apb(1'b0, `CTRL_OFS, 0);
			chk("ctrl_rd", r, 32'h0000000a);
			apb(1'b0, 12'h0f0, 0);
			chk("bad_err", e, 1);
			chk("bad_rd", r, 0);
			$display("t_regs done");
		end
	endtask
	// every rate code, then the external clock: one frame out, one pulse in
	task t_rates;
		int c, d, n0, k, lo;
		begin
			for (c = 0; c < 9; c++) begin
				d = dv[c];
				apb(1'b1, `CTRL_OFS, (c == 8) ? 32'h00000010 : c);
				apb(1'b1, `COUNT_OFS, 0);
				n0 = npulse;
				u_ir_far_model.send_byte(8'h4b, d);
				repeat (16 * d) @(posedge pclk);
				chk("tx_cnt", npulse - n0, 5);
				u_ir_far_model.ir_pulse();
				for (k = 0; k < 8 && uart_rx_out !== 1'b0; k++) @(posedge pclk);
				for (lo = 0; lo < 2000 && uart_rx_out === 1'b0; lo++)
					@(posedge pclk);
				tmo(lo == 2000);
				chk("rx_low", lo >= 15 * d && lo <= 16 * d + 2, 1);
				apb(1'b0, `COUNT_OFS, 0);
				chk("count", r, 32'h00010005);
			end
			$display("t_rates done");
		end
	endtask
	task t_mono;
		int n0;
		begin
			apb(1'b1, `CTRL_OFS, 32'h0000000d);
			n0 = npulse;
			u_ir_far_model.send_byte(8'h00, 48);
			repeat (768) @(posedge pclk);
			chk("mono_cnt", npulse - n0, 9);
			$display("t_mono done");
		end
	endtask
	// asleep by pin, then by control bit
	task t_sleep;
		int m, n0;
		begin
			for (m = 0; m < 2; m++) begin
				sleep_in <= (m == 0);
				apb(1'b1, `CTRL_OFS, m ? 32'h00000020 : 32'h00000000);
				n0 = npulse;
				u_ir_far_model.send_byte(8'h00, 2);
				u_ir_far_model.ir_pulse();
				repeat (8) @(posedge pclk);
				chk("sleep_rx", uart_rx_out, 1);
				chk("sleep_tx", npulse - n0, 0);
				apb(1'b0, `STATUS_OFS, 0);
				chk("sleep_st", r, 32'h00000004);
			end
			apb(1'b1, `CTRL_OFS, 0);
			$display("t_sleep done");
		end
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs;
		t_rates;
		t_mono;
		t_sleep;
		final_report;
	end
endmodule
